// File: hdl/udt_nak_resp.sv
// nak answer to in tokens while the bulk endpoint is empty
`timescale 1ns/1ns
module udt_nak_resp (
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_enable,
  input  wire logic i_in_token,
  input  wire logic i_crc_ok,
  output logic      o_nak
);

  logic nak_q;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nak_q <= 1'b0;
    end else begin
      nak_q <= i_enable && i_in_token && i_crc_ok;
    end
  end

  assign o_nak = nak_q;

endmodule : udt_nak_resp

// File: hdl/udt_pkg.sv
// package: register map, fields and types of the usb test control block
package udt_pkg;

  // register indices (word offsets, byte address = index * 4)
  localparam logic [3:0] REG_TEST_COUNTER_B    = 4'h0;
  localparam logic [3:0] REG_CORE_TEST_MODE    = 4'h1;
  localparam logic [3:0] REG_LINE_TEST_CONTROL = 4'h2;
  localparam logic [3:0] REG_BUS_APERTURE_SIZE = 4'h3;
  localparam logic [3:0] REG_IDENT_STRING_ONE  = 4'h4;
  localparam logic [3:0] REG_IDENT_STRING_TWO  = 4'h5;

  // field positions
  localparam int CNTB_LIMIT_LSB  = 0;
  localparam int CNTB_LIMIT_W    = 15;
  localparam int CNTB_LOAD_POS   = 15;
  localparam int TSEL_LSB        = 1;
  localparam int TSEL_W          = 4;
  localparam int SPEED_CFG_LSB   = 0;
  localparam int DRIVE_J_POS     = 2;
  localparam int DRIVE_K_POS     = 3;
  localparam int REPEAT_PKT_POS  = 4;
  localparam int RAW_OPMODE_POS  = 5;

  // reset values
  localparam logic [31:0] RST_TEST_COUNTER_B    = 32'h0000_0000;
  localparam logic [31:0] RST_CORE_TEST_MODE    = 32'h0000_0000;
  localparam logic [31:0] RST_LINE_TEST_CONTROL = 32'h0000_0000;

  // identification words, values arbitrary
  localparam logic [31:0] IDENT_WORD_ONE_DEF = 32'h5445_5354;
  localparam logic [31:0] IDENT_WORD_TWO_DEF = 32'h424c_4b31;

  // speed select codes
  localparam logic [1:0] SPD_NORMAL     = 2'h0;
  localparam logic [1:0] SPD_RESERVED   = 2'h1;
  localparam logic [1:0] SPD_FORCE_HS   = 2'h2;
  localparam logic [1:0] SPD_FORCE_FS   = 2'h3;

  // transceiver operating modes
  localparam logic [1:0] OPMODE_NORMAL  = 2'h0;
  localparam logic [1:0] OPMODE_NODRIVE = 2'h1;
  localparam logic [1:0] OPMODE_RAW     = 2'h2;

  // line states driven in test
  localparam logic [1:0] LINE_IDLE = 2'h0;
  localparam logic [1:0] LINE_J    = 2'h1;
  localparam logic [1:0] LINE_K    = 2'h2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] idx;
    logic [31:0] wdata;
  } udt_bus_req_type;

  typedef struct packed {
    logic [1:0] speed_cfg;
    logic       drive_j_state;
    logic       drive_k_state;
    logic       repeat_test_packet;
    logic       raw_opmode_force;
  } udt_line_ctl_type;

  typedef struct packed {
    logic       in_token;
    logic       crc_ok;
    logic       chirp_seen;
    logic       bus_reset;
  } udt_line_evt_type;

endpackage : udt_pkg

// File: hdl/udt_speed_fsm.sv
// speed negotiation state machine
`timescale 1ns/1ns
module udt_speed_fsm (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic [1:0] i_speed_cfg,
  input  wire logic       i_bus_reset,
  input  wire logic       i_chirp_seen,
  output logic            o_high_speed,
  output logic            o_chirp_active
);

  typedef enum logic [3:0] {
    ST_FULL  = 4'b0001,
    ST_IDENT = 4'b0010,
    ST_HIGH  = 4'b0100,
    ST_FHIGH = 4'b1000
  } udt_speed_state_type;

  udt_speed_state_type state_q;
  udt_speed_state_type state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_FULL: begin
        if (i_speed_cfg == udt_pkg::SPD_FORCE_HS) begin
          state_d = ST_FHIGH;
        end else if (i_speed_cfg == udt_pkg::SPD_NORMAL && i_bus_reset) begin
          state_d = ST_IDENT;
        end
      end
      ST_IDENT: begin
        if (i_speed_cfg == udt_pkg::SPD_FORCE_HS) begin
          state_d = ST_FHIGH;
        end else if (i_speed_cfg != udt_pkg::SPD_NORMAL) begin
          state_d = ST_FULL;
        end else if (i_chirp_seen) begin
          state_d = ST_HIGH;
        end else if (!i_bus_reset) begin
          state_d = ST_FULL;
        end
      end
      ST_HIGH: begin
        if (i_speed_cfg == udt_pkg::SPD_FORCE_FS) begin
          state_d = ST_FULL;
        end else if (i_speed_cfg == udt_pkg::SPD_FORCE_HS) begin
          state_d = ST_FHIGH;
        end else if (i_bus_reset) begin
          state_d = ST_IDENT;
        end
      end
      ST_FHIGH: begin
        if (i_speed_cfg != udt_pkg::SPD_FORCE_HS) begin
          state_d = ST_FULL;
        end
      end
      default: state_d = ST_FULL;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_FULL;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_high_speed   = (state_q == ST_HIGH) || (state_q == ST_FHIGH);
  assign o_chirp_active = (state_q == ST_IDENT);

endmodule : udt_speed_fsm

// File: hdl/udt_test_ctrl.sv
// test and identification registers of the usb device controller
`timescale 1ns/1ns
module udt_test_ctrl #(
  parameter int          ADDR_WIDTH     = 14,
  parameter logic [31:0] IDENT_WORD_ONE = udt_pkg::IDENT_WORD_ONE_DEF,
  parameter logic [31:0] IDENT_WORD_TWO = udt_pkg::IDENT_WORD_TWO_DEF
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_resetn,
  input  wire udt_pkg::udt_bus_req_type  i_bus_req,
  output logic [31:0]                    o_rdata,
  input  wire udt_pkg::udt_line_evt_type i_line_evt,
  input  wire logic                      i_ep_empty,
  input  wire logic                      i_tx_done,
  output logic [1:0]                     o_line_state,
  output logic [1:0]                     o_opmode,
  output logic                           o_test_tx_start,
  output logic                           o_hs_rx_mode,
  output logic                           o_nak,
  output logic                           o_high_speed,
  output logic                           o_chirp_active,
  output logic [udt_pkg::TSEL_W-1:0]     o_core_test_select,
  output logic [udt_pkg::CNTB_LIMIT_W-1:0] o_counter_b_limit,
  output logic                           o_counter_b_load
);

  logic [31:0] cntb_q;
  logic [31:0] tmode_q;
  logic [31:0] tst_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  line_q;
  logic [1:0]  opmode_q;
  logic        tx_busy_q;
  logic        tx_start_q;
  logic [1:0]  speed_cfg;
  logic        se0_nak_test;
  logic        hs;
  logic        wr_cntb;
  logic        wr_tmode;
  logic        wr_tst;
  logic [31:0] aperture;

  udt_pkg::udt_line_ctl_type ctl;

  function automatic logic hit(input udt_pkg::udt_bus_req_type r,
                               input logic [3:0] idx);
    hit = r.wr && (r.idx == idx);
  endfunction : hit

  assign wr_cntb  = hit(i_bus_req, udt_pkg::REG_TEST_COUNTER_B);
  assign wr_tmode = hit(i_bus_req, udt_pkg::REG_CORE_TEST_MODE);
  assign wr_tst   = hit(i_bus_req, udt_pkg::REG_LINE_TEST_CONTROL);

  assign ctl.speed_cfg =
    tst_q[udt_pkg::SPEED_CFG_LSB +: 2];
  assign ctl.drive_j_state      = tst_q[udt_pkg::DRIVE_J_POS];
  assign ctl.drive_k_state      = tst_q[udt_pkg::DRIVE_K_POS];
  assign ctl.repeat_test_packet = tst_q[udt_pkg::REPEAT_PKT_POS];
  assign ctl.raw_opmode_force   = tst_q[udt_pkg::RAW_OPMODE_POS];

  // reserved code behaves as normal negotiation
  assign speed_cfg = (ctl.speed_cfg == udt_pkg::SPD_RESERVED) ?
                     udt_pkg::SPD_NORMAL : ctl.speed_cfg;

  assign aperture = 32'h0000_0001 << ADDR_WIDTH;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cntb_q  <= udt_pkg::RST_TEST_COUNTER_B;
      tmode_q <= udt_pkg::RST_CORE_TEST_MODE;
      tst_q   <= udt_pkg::RST_LINE_TEST_CONTROL;
    end else begin
      if (wr_cntb) begin
        cntb_q <= {16'h0000, i_bus_req.wdata[15:0]};
      end
      if (wr_tmode) begin
        tmode_q <= {27'h000_0000,
                    i_bus_req.wdata[udt_pkg::TSEL_LSB +: udt_pkg::TSEL_W],
                    1'b0};
      end
      if (wr_tst) begin
        tst_q <= {26'h000_0000, i_bus_req.wdata[5:0]};
      end
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (i_bus_req.rd) begin
      unique case (i_bus_req.idx)
        udt_pkg::REG_TEST_COUNTER_B:    rdata_d = cntb_q;
        udt_pkg::REG_CORE_TEST_MODE:    rdata_d = tmode_q;
        udt_pkg::REG_LINE_TEST_CONTROL: rdata_d = tst_q;
        udt_pkg::REG_BUS_APERTURE_SIZE: rdata_d = aperture;
        udt_pkg::REG_IDENT_STRING_ONE:  rdata_d = IDENT_WORD_ONE;
        udt_pkg::REG_IDENT_STRING_TWO:  rdata_d = IDENT_WORD_TWO;
        default:                        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  udt_speed_fsm u_speed (
    .i_ref_clk      (i_ref_clk),
    .i_resetn       (i_resetn),
    .i_speed_cfg    (speed_cfg),
    .i_bus_reset    (i_line_evt.bus_reset),
    .i_chirp_seen   (i_line_evt.chirp_seen),
    .o_high_speed   (hs),
    .o_chirp_active (o_chirp_active)
  );

  // se0 nak test: forced hs, no j, k or repeat packet bits, endpoint left empty
  assign se0_nak_test = (speed_cfg == udt_pkg::SPD_FORCE_HS) && hs &&
                        !ctl.drive_j_state && !ctl.drive_k_state &&
                        !ctl.repeat_test_packet && i_ep_empty;

  udt_nak_resp u_nak (
    .i_ref_clk  (i_ref_clk),
    .i_resetn   (i_resetn),
    .i_enable   (se0_nak_test),
    .i_in_token (i_line_evt.in_token),
    .i_crc_ok   (i_line_evt.crc_ok),
    .o_nak      (o_nak)
  );

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      line_q     <= udt_pkg::LINE_IDLE;
      opmode_q   <= udt_pkg::OPMODE_NORMAL;
      tx_busy_q  <= 1'b0;
      tx_start_q <= 1'b0;
    end else begin
      if (ctl.drive_j_state) begin
        line_q <= udt_pkg::LINE_J;
      end else if (ctl.drive_k_state) begin
        line_q <= udt_pkg::LINE_K;
      end else begin
        line_q <= udt_pkg::LINE_IDLE;
      end
      opmode_q <= ctl.raw_opmode_force ?
                  udt_pkg::OPMODE_RAW : udt_pkg::OPMODE_NORMAL;
      // restart the stored packet after each completed send
      tx_start_q <= ctl.repeat_test_packet && !tx_busy_q &&
                    !tx_start_q;
      if (tx_start_q) begin
        tx_busy_q <= 1'b1;
      end else if (i_tx_done || !ctl.repeat_test_packet) begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  assign o_rdata            = rdata_q;
  assign o_line_state       = line_q;
  assign o_opmode           = opmode_q;
  assign o_test_tx_start    = tx_start_q;
  assign o_hs_rx_mode       = se0_nak_test;
  assign o_high_speed       = hs;
  assign o_core_test_select = tmode_q[udt_pkg::TSEL_LSB +: udt_pkg::TSEL_W];
  assign o_counter_b_limit  =
    cntb_q[udt_pkg::CNTB_LIMIT_LSB +: udt_pkg::CNTB_LIMIT_W];
  assign o_counter_b_load   = cntb_q[udt_pkg::CNTB_LOAD_POS];

endmodule : udt_test_ctrl

// File: tb/test_udt_test_ctrl.sv
// testbench: register and line tests of the test control block
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module test_udt_test_ctrl;
  logic                      i_ref_clk = 1'b0;
  logic                      i_resetn  = 1'b0;
  logic                      ep_empty  = 1'b1;
  udt_pkg::udt_bus_req_type  req       = '0;
  udt_pkg::udt_line_evt_type evt;
  logic                      tx_done, tx_start, hs_rx, nak, hs;
  logic [31:0]               rdata;
  logic [1:0]                line_state, opmode;
  logic                      chirp, cb_load;
  logic [3:0]                tsel;
  logic [14:0]               cb_limit;
  int                        chirps = 0;
  logic [31:0]               tv [4] = '{32'h6, 32'ha, 32'h12, 32'h22};
  int                        starts = 0;
  int                        fail_count = 0;
  int                        n_tests = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (tx_start) starts++;
  always @(posedge i_ref_clk) if (chirp) chirps++;
  udt_test_ctrl #(.ADDR_WIDTH(10)) u_udt_test_ctrl (
    .i_ref_clk, .i_resetn, .i_bus_req(req), .o_rdata(rdata),
    .i_line_evt(evt), .i_ep_empty(ep_empty), .i_tx_done(tx_done),
    .o_line_state(line_state), .o_opmode(opmode), .o_test_tx_start(tx_start),
    .o_hs_rx_mode(hs_rx), .o_nak(nak), .o_high_speed(hs),
    .o_chirp_active(chirp), .o_core_test_select(tsel),
    .o_counter_b_limit(cb_limit), .o_counter_b_load(cb_load));
  udt_host_model u_udt_host_model (.i_ref_clk, .i_test_tx_start(tx_start),
    .o_line_evt(evt), .o_tx_done(tx_done));
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    @(posedge i_ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(posedge i_ref_clk);
    req.wr <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    #1;
  endtask : wr
  task automatic rchk(input logic [3:0] idx, input logic [31:0] e);
    @(posedge i_ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 32'h0};
    @(posedge i_ref_clk);
    req.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rchk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rchk(4'h0, udt_pkg::RST_TEST_COUNTER_B);
    rchk(4'h1, udt_pkg::RST_CORE_TEST_MODE);
    rchk(4'h2, udt_pkg::RST_LINE_TEST_CONTROL);
    `CHK(tsel, 4'h0)
    `CHK(cb_load, 1'b0)
    `CHK(chirp, 1'b0)
    wr(4'h3, 32'h0);
    rchk(4'h3, 32'h0000_0400);
    rchk(4'h4, udt_pkg::IDENT_WORD_ONE_DEF);
    rchk(4'h5, udt_pkg::IDENT_WORD_TWO_DEF);
    rchk(4'h6, 32'h0);
    wr(4'h0, 32'hffff_ffff);
    rchk(4'h0, 32'h0000_ffff);
    `CHK(cb_limit, 15'h7fff)
    `CHK(cb_load, 1'b1)
    wr(4'h1, 32'hffff_ffff);
    rchk(4'h1, 32'h0000_001e);
    `CHK(tsel, 4'hf)
    wr(4'h2, 32'h3);
    u_udt_host_model.usb_reset(1'b1);
    `CHK(hs, 1'b0)
    `CHK(chirps, 0)
    wr(4'h2, 32'h0);
    u_udt_host_model.usb_reset(1'b1);
    `CHK(hs, 1'b1)
    `CHK(chirps > 0, 1'b1)
    u_udt_host_model.usb_reset(1'b0);
    `CHK(hs, 1'b0)
    wr(4'h2, 32'h2);
    `CHK(hs, 1'b1)
    `CHK(hs_rx, 1'b1)
    u_udt_host_model.in_token(1'b1);
    `CHK(nak, 1'b1)
    u_udt_host_model.in_token(1'b0);
    `CHK(nak, 1'b0)
    @(posedge i_ref_clk);
    ep_empty <= 1'b0;
    #1;
    `CHK(hs_rx, 1'b0)
    @(posedge i_ref_clk);
    ep_empty <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(4'h2, tv[k]);
      `CHK(line_state, k == 0 ? udt_pkg::LINE_J : k == 1 ? udt_pkg::LINE_K :
        udt_pkg::LINE_IDLE)
      `CHK(opmode, k == 3 ? udt_pkg::OPMODE_RAW : udt_pkg::OPMODE_NORMAL)
      if (k == 2) begin
        repeat (20) @(posedge i_ref_clk);
        `CHK(starts > 2, 1'b1)
      end
    end
    wr(4'h2, 32'h2);
    `CHK(line_state, udt_pkg::LINE_IDLE)
    summarize();
  end
endmodule : test_udt_test_ctrl

// File: tb/udt_host_model.sv
// model: usb host side, line events and test packet completion
`timescale 1ns/1ns
module udt_host_model (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_test_tx_start,
  output udt_pkg::udt_line_evt_type o_line_evt,
  output logic                      o_tx_done
);
  logic [2:0] busy_q = 3'h0;
  initial o_line_evt = '0;
  initial o_tx_done = 1'b0;
  // each packet takes four cycles on the line
  always @(posedge i_ref_clk) begin
    o_tx_done <= (busy_q == 3'h1);
    if (i_test_tx_start) busy_q <= 3'h4;
    else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
  end
  task automatic usb_reset(input logic chirp);
    @(posedge i_ref_clk);
    o_line_evt.bus_reset <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    o_line_evt.chirp_seen <= chirp;
    @(posedge i_ref_clk);
    o_line_evt <= '0;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask : usb_reset
  task automatic in_token(input logic crc);
    @(posedge i_ref_clk);
    o_line_evt.in_token <= 1'b1;
    o_line_evt.crc_ok <= crc;
    @(posedge i_ref_clk);
    o_line_evt <= '0;
    #1;
  endtask : in_token
endmodule : udt_host_model

// File: tb/udt_test_ctrl_chk.sv
// checker: port assertions of the test control block
`timescale 1ns/1ns
module udt_test_ctrl_chk #(
  parameter int ADDR_WIDTH = 14
) (
  input wire logic                      i_ref_clk,
  input wire logic                      i_resetn,
  input wire udt_pkg::udt_bus_req_type  i_bus_req,
  input wire logic [31:0]               o_rdata,
  input wire udt_pkg::udt_line_evt_type i_line_evt,
  input wire logic [1:0]                o_line_state,
  input wire logic [1:0]                o_opmode,
  input wire logic                      o_test_tx_start,
  input wire logic                      o_hs_rx_mode,
  input wire logic                      o_nak,
  input wire logic                      o_high_speed,
  input wire logic                      o_chirp_active
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire logic tst_wr;
  assign tst_wr = i_bus_req.wr && i_bus_req.idx == 4'h2;
  sequence tst_write(logic [31:0] m, logic [31:0] v);
    tst_wr && (i_bus_req.wdata & m) == v;
  endsequence
  chk_drive_j_line: assert property (tst_write(32'h4, 32'h4) |->
    ##2 o_line_state == udt_pkg::LINE_J) else $error("j state missing");
  chk_drive_k_line: assert property (tst_write(32'hc, 32'h8) |->
    ##2 o_line_state == udt_pkg::LINE_K) else $error("k state missing");
  chk_repeat_start: assert property (tst_write(32'h1c, 32'h10) |->
    ##[1:3] o_test_tx_start) else $error("no packet start");
  chk_raw_opmode: assert property (tst_write(32'h20, 32'h20) |->
    ##2 o_opmode == udt_pkg::OPMODE_RAW) else $error("opmode not raw");
  chk_force_high: assert property (tst_write(32'h3, 32'h2) |->
    ##2 o_high_speed) else $error("high speed not forced");
  chk_force_full: assert property (tst_write(32'h3, 32'h3) |->
    ##2 !o_high_speed [*4]) else $error("full speed not held");
  chk_chirp_high: assert property (o_chirp_active &&
    i_line_evt.chirp_seen |=> o_high_speed) else $error("no switch to hs");
  chk_rx_mode_hs: assert property (o_hs_rx_mode |-> o_high_speed)
    else $error("rx mode outside hs");
  chk_nak_answer: assert property (o_hs_rx_mode && i_line_evt.in_token &&
    i_line_evt.crc_ok |=> o_nak) else $error("nak missing");
  chk_nak_cause: assert property (o_nak |->
    $past(i_line_evt.in_token && i_line_evt.crc_ok)) else $error("stray nak");
  chk_aperture_value: assert property (i_bus_req.rd &&
    i_bus_req.idx == 4'h3 |=> o_rdata == (32'h0000_0001 << ADDR_WIDTH))
    else $error("aperture wrong");
endmodule : udt_test_ctrl_chk
bind udt_test_ctrl udt_test_ctrl_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .i_ref_clk, .i_resetn, .i_bus_req, .o_rdata, .i_line_evt, .o_line_state,
  .o_opmode, .o_test_tx_start, .o_hs_rx_mode, .o_nak, .o_high_speed,
  .o_chirp_active);
